// *** logic/smb_cfg_target.sv ***
/*
 Target end: byte-wide configuration registers of a four-output clock
 buffer reached by block write and block read over the two-wire link.
 Assumes the host makes the link clock; it is sampled here by clk_i.
*/
// Summary of operation
// - target only, block read and write
// - address 1101 plus latched strap bits
// - stop after any byte, keep earlier bytes
// - write: offset, count, then data bytes
// - read: offset, restart, count then data
// - host nacks last read byte, then stops
// - register 0 output enables, reset one
// - register 1 top bits show latched mode
// - source select bit picks latched or software
// - software mode bits, reset zero
// - read byte count from count register
`timescale 1ns/100ps
module smb_cfg_target
	import smb_cfg_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // async reset, active low
	smb_link_if.target link, // two-wire link
	input wire logic [2:0] target_addr_strap_i, // low address bits strap
	input wire logic [1:0] mode_strap_i, // loop mode strap
	input wire logic [3:0] out_pair_oe_b_i, // per-pair enable pins
	output logic [3:0] out_pair_en_o, // pair running when high
	output logic [1:0] loop_mode_o, // effective loop mode
	output logic [1:0] amplitude_o // output amplitude code
);
	typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_txack} state_t;
	typedef enum logic [1:0] {b_addr, b_offset, b_count, b_data} byte_t;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic [3:0] oe_s1;
	logic [3:0] oe_s2;
	logic [2:0] addr_s1;
	logic [2:0] addr_s2;
	logic [1:0] mode_s1;
	logic [1:0] mode_s2;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			oe_s1 <= 4'hF;
			oe_s2 <= 4'hF;
			addr_s1 <= 3'h0;
			addr_s2 <= 3'h0;
			mode_s1 <= 2'h0;
			mode_s2 <= 2'h0;
		end else begin
			scl_s <= {scl_s[1:0], link.scl};
			sda_s <= {sda_s[1:0], link.sda};
			oe_s1 <= out_pair_oe_b_i;
			oe_s2 <= oe_s1;
			addr_s1 <= target_addr_strap_i;
			addr_s2 <= addr_s1;
			mode_s1 <= mode_strap_i;
			mode_s2 <= mode_s1;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start_seen = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	assign stop_seen = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

	// straps are caught once, a few cycles after reset, never tracked later
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic taken;
	logic next_taken;
	logic [2:0] addr_lat;
	logic [2:0] next_addr_lat;
	logic [1:0] mode_lat;
	logic [1:0] next_mode_lat;

	always_comb begin
		next_settle = settle;
		next_taken = taken;
		next_addr_lat = addr_lat;
		next_mode_lat = mode_lat;
		if (!taken) begin
			if (settle == STRAP_SETTLE) begin
				next_taken = 1'b1;
				next_addr_lat = addr_s2;
				next_mode_lat = mode_s2;
			end else begin
				next_settle = settle + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			settle <= 2'h0;
			taken <= 1'b0;
			addr_lat <= 3'h0;
			mode_lat <= 2'h0;
		end else begin
			settle <= next_settle;
			taken <= next_taken;
			addr_lat <= next_addr_lat;
			mode_lat <= next_mode_lat;
		end
	end

	state_t state;
	state_t next_state;
	byte_t bidx;
	byte_t next_bidx;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic rw;
	logic next_rw;
	logic ack_ok;
	logic next_ack_ok;
	logic sda_low;
	logic next_sda_low;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [7:0] reg_oe;
	logic [7:0] next_reg_oe;
	logic [5:0] reg_mode_lo;
	logic [5:0] next_reg_mode_lo;
	logic [7:0] reg_bcount;
	logic [7:0] next_reg_bcount;
	logic [7:0] rd_byte;

	always_comb begin
		case (ptr)
			OFS_OUT_EN: rd_byte = reg_oe;
			OFS_MODE: rd_byte = {mode_lat, reg_mode_lo};
			OFS_BCOUNT: rd_byte = reg_bcount;
			default: rd_byte = UNMAPPED_RD;
		endcase
	end

	always_comb begin
		next_state = state;
		next_bidx = bidx;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_rw = rw;
		next_ack_ok = ack_ok;
		next_sda_low = sda_low;
		next_ptr = ptr;
		next_reg_oe = reg_oe;
		next_reg_mode_lo = reg_mode_lo;
		next_reg_bcount = reg_bcount;
		case (state)
			st_idle: begin
			end
			st_rx: begin
				if (scl_rise) begin
					next_shreg = {shreg[6:0], sda_s[2]};
					next_bitcnt = bitcnt + 4'h1;
				end else if (scl_fall && bitcnt == 4'h8) begin
					next_state = st_ack;
					next_sda_low = 1'b1;
					next_bitcnt = 4'h0;
					case (bidx)
						b_addr: begin
							if (shreg[7:1] == {ADDR_HI, addr_lat}) begin
								next_rw = shreg[0];
								next_bidx = b_offset;
							end else begin
								next_state = st_idle;
								next_sda_low = 1'b0;
							end
						end
						b_offset: begin
							next_ptr = shreg;
							next_bidx = b_count;
						end
						// the count is acknowledged only; the stop marks the end
						b_count: next_bidx = b_data;
						default: begin
							case (ptr)
								OFS_OUT_EN: next_reg_oe = merge(reg_oe, shreg, OUT_EN_WMASK);
								OFS_MODE: next_reg_mode_lo = (reg_mode_lo & ~MODE_LO_WMASK)
									| (shreg[5:0] & MODE_LO_WMASK);
								OFS_BCOUNT: next_reg_bcount = merge(reg_bcount, shreg, BCOUNT_WMASK);
								default: next_reg_oe = reg_oe;
							endcase
							next_ptr = ptr + 8'h1;
						end
					endcase
				end
			end
			st_ack: begin
				if (scl_fall) begin
					if (rw) begin
						next_shreg = reg_bcount;
						next_sda_low = ~reg_bcount[7];
						next_state = st_tx;
					end else begin
						next_sda_low = 1'b0;
						next_state = st_rx;
					end
				end
			end
			st_tx: begin
				if (scl_rise) begin
					next_bitcnt = bitcnt + 4'h1;
				end else if (scl_fall) begin
					if (bitcnt == 4'h8) begin
						next_sda_low = 1'b0;
						next_bitcnt = 4'h0;
						next_state = st_txack;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_low = ~shreg[6];
					end
				end
			end
			st_txack: begin
				if (scl_rise) begin
					next_ack_ok = ~sda_s[2];
				end else if (scl_fall) begin
					if (ack_ok) begin
						next_shreg = rd_byte;
						next_sda_low = ~rd_byte[7];
						next_ptr = ptr + 8'h1;
						next_state = st_tx;
					end else begin
						next_state = st_idle;
					end
				end
			end
			default: next_state = st_idle;
		endcase
		if (start_seen) begin
			// a repeated start keeps the pointer that the write phase set
			next_state = st_rx;
			next_bidx = b_addr;
			next_bitcnt = 4'h0;
			next_sda_low = 1'b0;
		end
		if (stop_seen) begin
			next_state = st_idle;
			next_sda_low = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= st_idle;
			bidx <= b_addr;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			rw <= 1'b0;
			ack_ok <= 1'b0;
			sda_low <= 1'b0;
			ptr <= 8'h00;
			reg_oe <= OUT_EN_RST;
			reg_mode_lo <= MODE_LO_RST;
			reg_bcount <= BCOUNT_RST;
		end else begin
			state <= next_state;
			bidx <= next_bidx;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			rw <= next_rw;
			ack_ok <= next_ack_ok;
			sda_low <= next_sda_low;
			ptr <= next_ptr;
			reg_oe <= next_reg_oe;
			reg_mode_lo <= next_reg_mode_lo;
			reg_bcount <= next_reg_bcount;
		end
	end

	// the target never drives the clock and only ever pulls data low
	assign link.sda_d = 1'b0;
	assign link.sda_d_oe_b = ~sda_low;

	logic [3:0] next_out_pair_en;
	logic [1:0] next_loop_mode;
	logic [1:0] next_amplitude;

	always_comb begin
		next_out_pair_en[0] = reg_oe[OE_BIT0] & ~oe_s2[0];
		next_out_pair_en[1] = reg_oe[OE_BIT1] & ~oe_s2[1];
		next_out_pair_en[2] = reg_oe[OE_BIT2] & ~oe_s2[2];
		next_out_pair_en[3] = reg_oe[OE_BIT3] & ~oe_s2[3];
		next_loop_mode = reg_mode_lo[SW_SEL_BIT] ? reg_mode_lo[SW_MODE_LSB +: 2] : mode_lat;
		next_amplitude = reg_mode_lo[AMP_LSB +: 2];
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_pair_en_o <= 4'h0;
			loop_mode_o <= 2'h0;
			amplitude_o <= 2'h0;
		end else begin
			out_pair_en_o <= next_out_pair_en;
			loop_mode_o <= next_loop_mode;
			amplitude_o <= next_amplitude;
		end
	end
endmodule

// *** shared/smb_cfg_pkg.sv ***
/*
 Constants shared by the two ends of the clock-buffer configuration link:
 register offsets, field positions, reset values and link timing.
 Assumes a 250 MHz system clock on both ends.
*/
package smb_cfg_pkg;
	localparam logic [3:0] ADDR_HI = 4'hD;
	localparam logic [7:0] OFS_OUT_EN = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h01;
	localparam logic [7:0] OFS_BCOUNT = 8'h07;
	localparam logic [7:0] OUT_EN_RST = 8'hFF;
	localparam logic [7:0] OUT_EN_WMASK = 8'h6A;
	localparam logic [5:0] MODE_LO_RST = 6'h06;
	localparam logic [5:0] MODE_LO_WMASK = 6'h3B;
	localparam logic [7:0] BCOUNT_RST = 8'h08;
	localparam logic [7:0] BCOUNT_WMASK = 8'h1F;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam int OE_BIT0 = 1;
	localparam int OE_BIT1 = 3;
	localparam int OE_BIT2 = 5;
	localparam int OE_BIT3 = 6;
	localparam int SW_SEL_BIT = 5;
	localparam int SW_MODE_LSB = 3;
	localparam int AMP_LSB = 0;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCL_PERIOD_NS = 160;
	localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage

// *** shared/smb_link_if.sv ***
/*
 Two-wire link between the configuration host and the target.
 Assumes both wires are pulled up; an end pulls low by clearing its enable.
*/
`timescale 1ns/100ps
interface smb_link_if;
	logic scl_h;
	logic scl_h_oe_b;
	logic sda_h;
	logic sda_h_oe_b;
	logic sda_d;
	logic sda_d_oe_b;
	logic scl;
	logic sda;
	assign scl = scl_h_oe_b | scl_h;
	assign sda = (sda_h_oe_b | sda_h) & (sda_d_oe_b | sda_d);
	modport host (output scl_h, scl_h_oe_b, sda_h, sda_h_oe_b, input scl, sda);
	modport target (output sda_d, sda_d_oe_b, input scl, sda);
endinterface

// *** logic/smb_cfg_host.sv ***
/*
 Host end: issues one block write or block read per request and makes the
 link clock by dividing clk_i; each bit takes four quarter periods.
 Assumes the target never stretches the clock.
*/
`timescale 1ns/100ps
module smb_cfg_host
	import smb_cfg_pkg::*;
#(
	parameter int QTR = SCL_QTR_CYC
)
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // async reset, active low
	smb_link_if.host link, // two-wire link
	input wire logic go_i, // start a transfer, pulse
	input wire logic rd_i, // 1 block read, 0 block write
	input wire logic [6:0] taddr_i, // target address
	input wire logic [7:0] offset_i, // first register
	input wire logic [7:0] count_i, // data bytes to move
	input wire logic [7:0] wdata_i, // next write byte
	output logic wdata_take_o, // wdata_i taken, pulse
	output logic [7:0] rdata_o, // received byte
	output logic rvalid_o, // rdata_o new, pulse
	output logic busy_o, // transfer in progress
	output logic nack_o // last transfer refused
);
	typedef enum logic [1:0] {h_idle, h_start, h_bits, h_stop} hstate_t;

	logic [2:0] sda_s;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sda_s <= 3'h7;
		end else begin
			sda_s <= {sda_s[1:0], link.sda};
		end
	end

	hstate_t st;
	hstate_t next_st;
	logic [7:0] div;
	logic [7:0] next_div;
	logic [1:0] q;
	logic [1:0] next_q;
	logic [3:0] bit_i;
	logic [3:0] next_bit_i;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] bn;
	logic [7:0] next_bn;
	logic samp;
	logic next_samp;
	logic rd;
	logic next_rd;
	logic [6:0] ta;
	logic [6:0] next_ta;
	logic [7:0] ofs;
	logic [7:0] next_ofs;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic scl_rel;
	logic next_scl_rel;
	logic sda_rel;
	logic next_sda_rel;
	logic next_take;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic next_busy;
	logic next_nack;
	logic tick;
	logic rxing;
	logic last_rx;
	logic [7:0] nbyte;
	logic [8:0] bn_n;

	assign tick = div == 8'(QTR - 1);
	assign rxing = rd && bn >= 8'h3;
	assign last_rx = {1'b0, bn} == {1'b0, cnt} + 9'h3;

	always_comb begin
		bn_n = {1'b0, bn} + 9'h1;
		case (bn_n[7:0])
			8'h0: nbyte = {ta, 1'b0};
			8'h1: nbyte = ofs;
			8'h2: nbyte = rd ? {ta, 1'b1} : cnt;
			default: nbyte = wdata_i;
		endcase
	end

	always_comb begin
		next_st = st;
		next_div = tick ? 8'h0 : div + 8'h1;
		next_q = q;
		next_bit_i = bit_i;
		next_shreg = shreg;
		next_bn = bn;
		next_samp = samp;
		next_rd = rd;
		next_ta = ta;
		next_ofs = ofs;
		next_cnt = cnt;
		next_take = 1'b0;
		next_rdata = rdata_o;
		next_rvalid = 1'b0;
		next_busy = busy_o;
		next_nack = nack_o;
		if (tick && st != h_idle) begin
			next_q = q + 2'h1;
			if (q == 2'h2) begin
				next_samp = sda_s[2];
			end
		end
		case (st)
			h_idle: begin
				next_scl_rel = 1'b1;
				next_sda_rel = 1'b1;
				if (go_i) begin
					next_rd = rd_i;
					next_ta = taddr_i;
					next_ofs = offset_i;
					next_cnt = count_i;
					next_bn = 8'hFF;
					next_busy = 1'b1;
					next_nack = 1'b0;
					next_q = 2'h0;
					next_div = 8'h0;
					next_st = h_start;
				end
			end
			h_start: begin
				next_scl_rel = q == 2'h1 || q == 2'h2;
				next_sda_rel = q < 2'h2;
				if (tick && q == 2'h3) begin
					next_bn = bn_n[7:0];
					next_shreg = nbyte;
					next_bit_i = 4'h0;
					next_st = h_bits;
				end
			end
			h_bits: begin
				next_scl_rel = q == 2'h1 || q == 2'h2;
				if (bit_i < 4'h8) begin
					next_sda_rel = rxing | shreg[7];
				end else begin
					next_sda_rel = rxing ? last_rx : 1'b1;
				end
				if (tick && q == 2'h3) begin
					if (bit_i < 4'h8) begin
						next_shreg = {shreg[6:0], samp};
						next_bit_i = bit_i + 4'h1;
					end else begin
						next_bit_i = 4'h0;
						if (rxing) begin
							next_rdata = shreg;
							next_rvalid = 1'b1;
						end
						if (!rxing && samp) begin
							next_nack = 1'b1;
							next_st = h_stop;
						end else if (rd && bn == 8'h1) begin
							next_st = h_start;
						end else if (rd ? last_rx : bn_n == {1'b0, cnt} + 9'h3) begin
							next_st = h_stop;
						end else begin
							next_bn = bn_n[7:0];
							next_shreg = nbyte;
							next_take = !rd && bn_n >= 9'h3;
						end
					end
				end
			end
			default: begin
				next_scl_rel = q != 2'h0;
				next_sda_rel = q >= 2'h2;
				if (tick && q == 2'h3) begin
					next_busy = 1'b0;
					next_st = h_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= h_idle;
			div <= 8'h0;
			q <= 2'h0;
			bit_i <= 4'h0;
			shreg <= 8'h00;
			bn <= 8'h00;
			samp <= 1'b1;
			rd <= 1'b0;
			ta <= 7'h00;
			ofs <= 8'h00;
			cnt <= 8'h00;
			scl_rel <= 1'b1;
			sda_rel <= 1'b1;
			wdata_take_o <= 1'b0;
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
			busy_o <= 1'b0;
			nack_o <= 1'b0;
		end else begin
			st <= next_st;
			div <= next_div;
			q <= next_q;
			bit_i <= next_bit_i;
			shreg <= next_shreg;
			bn <= next_bn;
			samp <= next_samp;
			rd <= next_rd;
			ta <= next_ta;
			ofs <= next_ofs;
			cnt <= next_cnt;
			scl_rel <= next_scl_rel;
			sda_rel <= next_sda_rel;
			wdata_take_o <= next_take;
			rdata_o <= next_rdata;
			rvalid_o <= next_rvalid;
			busy_o <= next_busy;
			nack_o <= next_nack;
		end
	end

	assign link.scl_h = 1'b0;
	assign link.sda_h = 1'b0;
	assign link.scl_h_oe_b = scl_rel;
	assign link.sda_h_oe_b = sda_rel;
endmodule

// *** testbench/smb_cfg_checker.sv ***
/*
 Concurrent checks on the two-wire link and the target's configuration outputs.
 Assumes the host runs with QTR clocks per quarter bit and straps held from reset.
*/
`timescale 1ns/100ps
module smb_cfg_checker
	import smb_cfg_pkg::*;
#(
	parameter int QTR = SCL_QTR_CYC
)
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic scl, // resolved clock wire
	input wire logic sda, // resolved data wire
	input wire logic sda_d_oe_b, // target data enable
	input wire logic [3:0] out_pair_oe_b_i, // pair enable pins
	input wire logic [3:0] out_pair_en_o, // pair running
	input wire logic [1:0] mode_strap_i, // loop mode strap
	input wire logic [1:0] loop_mode_o, // effective loop mode
	input wire logic [1:0] amplitude_o // amplitude code
);
	logic [7:0] hi_cnt;
	logic [7:0] next_hi_cnt;
	// saturates so a long idle high never wraps into a short count
	always_comb begin
		next_hi_cnt = hi_cnt;
		if (!scl)
			next_hi_cnt = 8'h00;
		else if (hi_cnt != 8'hFF)
			next_hi_cnt = hi_cnt + 8'h01;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= next_hi_cnt;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	target_no_start_a: assert property ($changed(sda_d_oe_b) |-> !scl)
		else $error("target moved data while clock high");
	clock_high_a: assert property ($fell(scl) |-> hi_cnt >= 8'(2 * QTR))
		else $error("clock high phase too short");
	target_hold_a: assert property (!sda_d_oe_b && $rose(scl) |-> !sda_d_oe_b [*4])
		else $error("target released data during clock high");
	stop_idle_a: assert property (scl && $rose(sda) |-> sda_d_oe_b [*8])
		else $error("target pulled data after stop");
	reset_release_a: assert property ($rose(rst_b_i) |-> sda_d_oe_b [*8])
		else $error("target pulled data after reset");
	amp_reset_a: assert property ($rose(rst_b_i) |=> amplitude_o == 2'h2)
		else $error("amplitude reset value wrong");
	mode_latch_a: assert property ($rose(rst_b_i) |-> ##8 loop_mode_o == mode_strap_i)
		else $error("loop mode not from latched strap");
	pair_gate_a: assert property ((out_pair_en_o & $past(out_pair_oe_b_i, 2) & $past(out_pair_oe_b_i, 3)) == 4'h0)
		else $error("pair running with its pin off");
endmodule

// *** testbench/smbus_clock_buffer_config_tb.sv ***
/*
 Self-checking bench: host and target ends joined by the link interface.
 Assumes a 250 MHz clock; read bytes are compared from a queue of notes.
*/
`timescale 1ns/100ps
module smbus_clock_buffer_config_tb;
	import smb_cfg_pkg::*;
	logic clk_i, rst_b_i, go_i, rd_i, wdata_take_o, rvalid_o, busy_o, nack_o;
	logic [6:0] taddr_i;
	logic [7:0] offset_i, count_i, wdata_i, rdata_o;
	logic [2:0] target_addr_strap_i, addr_l;
	logic [1:0] mode_strap_i, loop_mode_o, amplitude_o, strap_l;
	logic [3:0] out_pair_oe_b_i, out_pair_en_o;
	logic [7:0] r[8];
	logic [7:0] d[8];
	logic [7:0] q[$];
	int fails, samples_checked, i;
	smb_link_if link();
	smb_cfg_host #(.QTR(4)) smb_cfg_host_inst(.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .go_i(go_i),
		.rd_i(rd_i), .taddr_i(taddr_i), .offset_i(offset_i), .count_i(count_i), .wdata_i(wdata_i),
		.wdata_take_o(wdata_take_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .busy_o(busy_o), .nack_o(nack_o));
	smb_cfg_target smb_cfg_target_inst(.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
		.target_addr_strap_i(target_addr_strap_i), .mode_strap_i(mode_strap_i), .out_pair_oe_b_i(out_pair_oe_b_i),
		.out_pair_en_o(out_pair_en_o), .loop_mode_o(loop_mode_o), .amplitude_o(amplitude_o));
	smb_cfg_checker #(.QTR(4)) smb_cfg_checker_inst(.clk_i(clk_i), .rst_b_i(rst_b_i), .scl(link.scl),
		.sda(link.sda), .sda_d_oe_b(link.sda_d_oe_b), .out_pair_oe_b_i(out_pair_oe_b_i),
		.out_pair_en_o(out_pair_en_o), .mode_strap_i(mode_strap_i), .loop_mode_o(loop_mode_o),
		.amplitude_o(amplitude_o));

	task automatic conclude();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] rd_exp(input logic [7:0] p);
		case (p)
			OFS_OUT_EN: return r[0];
			OFS_MODE: return {strap_l, r[1][5:0]};
			OFS_BCOUNT: return r[7];
			default: return UNMAPPED_RD;
		endcase
	endfunction

	task automatic wr_model(input logic [7:0] p, input logic [7:0] v);
		if (p == OFS_OUT_EN)
			r[0] = (r[0] & ~OUT_EN_WMASK) | (v & OUT_EN_WMASK);
		else if (p == OFS_MODE)
			r[1][5:0] = (r[1][5:0] & ~MODE_LO_WMASK) | (v[5:0] & MODE_LO_WMASK);
		else if (p == OFS_BCOUNT)
			r[7] = (r[7] & ~BCOUNT_WMASK) | (v & BCOUNT_WMASK);
	endtask

	// pins are only changed with the host idle, so outputs have settled here
	task automatic outs();
		logic [3:0] en;
		logic [1:0] md;
		en = {r[0][OE_BIT3], r[0][OE_BIT2], r[0][OE_BIT1], r[0][OE_BIT0]} & ~out_pair_oe_b_i;
		md = r[1][SW_SEL_BIT] ? r[1][SW_MODE_LSB+:2] : strap_l;
		repeat (6) @(negedge clk_i);
		check({out_pair_en_o, loop_mode_o, amplitude_o}, {en, md, r[1][AMP_LSB+:2]});
	endtask

	task automatic rst_sys(input logic [2:0] a, input logic [1:0] m);
		@(negedge clk_i);
		rst_b_i = 1'b0;
		target_addr_strap_i = a;
		mode_strap_i = m;
		addr_l = a;
		strap_l = m;
		r[0] = OUT_EN_RST;
		r[1] = {2'h0, MODE_LO_RST};
		r[7] = BCOUNT_RST;
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		repeat (10) @(negedge clk_i);
	endtask

	task automatic xfer(input logic rd, input logic [2:0] lo, input logic [7:0] n0, input logic [7:0] x);
		int k, t;
		if (rd && lo == addr_l) begin
			q.push_back(r[7]);
			for (k = 0; k < x; k++)
				q.push_back(rd_exp(n0 + 8'(k)));
		end
		@(negedge clk_i);
		rd_i = rd;
		taddr_i = {ADDR_HI, lo};
		offset_i = n0;
		count_i = x;
		wdata_i = d[0];
		go_i = 1'b1;
		@(negedge clk_i);
		go_i = 1'b0;
		k = 1;
		for (t = 0; t < 20000 && busy_o !== 1'b0; t++) begin
			@(negedge clk_i);
			if (wdata_take_o === 1'b1 && k < 8) begin
				wdata_i = d[k];
				k++;
			end
		end
		if (t == 20000) begin
			fails++;
			$display("Error at %0t: transfer hung", $time);
		end
		if (!rd && lo == addr_l)
			for (k = 0; k < x; k++)
				wr_model(n0 + 8'(k), d[k]);
		check({7'h00, nack_o}, {7'h00, lo != addr_l});
	endtask

	// read bytes are looked at mid-cycle, clear of the edge that launches them
	always @(negedge clk_i) begin
		if (rvalid_o === 1'b1)
			check(rdata_o, (q.size() > 0) ? q.pop_front() : 8'hXX);
	end

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		#150000;
		fails++;
		conclude();
	end

	initial begin
		void'($urandom(32'hD1BB));
		rst_b_i = 1'b0;
		go_i = 1'b0;
		rd_i = 1'b0;
		taddr_i = 7'h00;
		offset_i = 8'h00;
		count_i = 8'h00;
		wdata_i = 8'h00;
		out_pair_oe_b_i = 4'h0;
		d = '{default: 8'h00};
		rst_sys(3'h5, 2'h2);
		outs();
		xfer(1'b1, addr_l, 8'h00, 8'h08);
		for (i = 0; i < 4; i++) begin
			d[0] = 8'($urandom);
			// software source is picked on odd passes so both mode sources are seen
			d[1] = {2'($urandom), i[0], i[1], ~i[0], 1'($urandom), i[1:0]};
			xfer(1'b0, addr_l, OFS_OUT_EN, 8'h02);
			outs();
			xfer(1'b1, addr_l, OFS_OUT_EN, 8'h02);
		end
		out_pair_oe_b_i = 4'($urandom);
		outs();
		d[0] = 8'($urandom);
		d[1] = 8'($urandom);
		xfer(1'b0, addr_l, 8'h06, 8'h02);
		xfer(1'b1, addr_l, 8'h05, 8'h03);
		xfer(1'b0, addr_l ^ 3'h1, OFS_OUT_EN, 8'h02);
		xfer(1'b0, addr_l, OFS_OUT_EN, 8'h00);
		outs();
		rst_sys(3'h2, 2'h1);
		// straps move after the catch; the latched values must stay in use
		target_addr_strap_i = 3'h7;
		mode_strap_i = 2'h2;
		xfer(1'b1, 3'h2, OFS_MODE, 8'h01);
		outs();
		repeat (10) @(negedge clk_i);
		check(8'(q.size()), 8'h00);
		conclude();
	end
endmodule
